/* rtl/lcvc_defs.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef LCVC_DEFS_SVH
`define LCVC_DEFS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LCVC_OFS_TRIM 8'he3
`define LCVC_OFS_CLKSEL 8'he4
`define LCVC_OFS_CTL 8'he5
`define LCVC_OFS_CMD 8'he6
`define LCVC_OFS_BYTE 8'he8
`define LCVC_OFS_STS_LO 8'hf0
`define LCVC_OFS_STS_HI 8'hf1
`define LCVC_OFS_MSK_LO 8'hf2
`define LCVC_OFS_MSK_HI 8'hf3
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define LCVC_SL_HI 3
`define LCVC_SL_LO 2
`define LCVC_EQ_HI 1
`define LCVC_EQ_LO 0
`define LCVC_T1_HI 7
`define LCVC_T1_LO 6
`define LCVC_E1_HI 5
`define LCVC_E1_LO 4
`define LCVC_MON_BIT 7
`define LCVC_RDEN_BIT 6
`define LCVC_CH_HI 3
`define LCVC_CH_LO 0
`define LCVC_RST_ALL_BIT 4
`define LCVC_ALLUPD_BIT 3
`define LCVC_BYTE_HI_BIT 2
`define LCVC_CHUPD_BIT 1
`define LCVC_RST_ONE_BIT 0
`define LCVC_REG_RESET 8'h00
`define LCVC_CNT_FULL 16'hffff
`define LCVC_NUM_CH 14
// ------------------------------------------------------------
// Timing and clock synthesis
// ------------------------------------------------------------
`define LCVC_MCLK_KHZ 50000
`define LCVC_MCLK_PERIOD_NS 20
`define LCVC_RST_HOLD_NS 1000
`define LCVC_RST_HOLD_CYC \
    ((`LCVC_RST_HOLD_NS + `LCVC_MCLK_PERIOD_NS - 1) / `LCVC_MCLK_PERIOD_NS)
`define LCVC_T1_BASE_KHZ 1544
`define LCVC_E1_BASE_KHZ 2048
`endif

/* rtl/lcvc_pkg.sv */
// Types shared by the counter and clock-out configuration block
package lcvc_pkg;
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcvc_bus_t;

    // Analog trim settings sent to the receiver
    typedef struct packed {
        logic [1:0] slicer_threshold;
        logic [1:0] eq_gain_reduce_db;
    } lcvc_trim_t;

    // Complete state of the block
    typedef struct packed {
        logic [7:0] trim_reg;
        logic [7:0] clksel_reg;
        logic [7:0] ctl_reg;
        logic [7:0] cmd_reg;
        logic [13:0][15:0] cnt_reg;
        logic [13:0][15:0] hold_reg;
        logic [13:0] ovf_reg;
        logic [13:0] sts_reg;
        logic [13:0] msk_reg;
        logic [5:0] rst_cyc_reg;
        logic [31:0] t1_acc_reg;
        logic [31:0] e1_acc_reg;
        logic [7:0] rdata_reg;
        logic irq_reg;
        logic [13:0] vstat_reg;
        lcvc_trim_t trim_out_reg;
        logic t1_pin_reg;
        logic e1_pin_reg;
    } lcvc_state_t;
endpackage

/* rtl/lcvc_top.sv */
// Global trim, reference clock out and violation counter control
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "lcvc_defs.svh"

// ------------------------------------------------------------
// Overview
// ------------------------------------------------------------
// Trim byte: slicer level and equalizer gain trim
// Clock select byte: rate of both reference clock pins
// Control byte: monitor source, readback gate, channel code
// Command byte: resets, updates and byte select, as levels
// Fourteen saturating violation counters, one per channel
// Holding registers give software a stable snapshot
// Overflow status is sticky and cleared by writing ones
// One clock domain; clk_en low freezes every flop
// Read data stand for one cycle, zero at all other times
// Unmapped addresses read zero and ignore writes
// Reset is asynchronous and clears all state to zero
// Limitation: commands act while held, software clears them
// Limitation: a held reset loses violations in that time
// Trade-off: reference clocks come from phase accumulators,
// so edges jitter by one mclk period but the mean rate is within 1 ppm
// Trade-off: one wide state struct keeps the reset uniform
// Hazard: status set beats a clear in the same cycle, so an
// overflow is never lost to a racing software clear

module lcvc_top (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Line side violation pulses, one per channel
    input wire logic [13:0] line_code_violation,
    // Per-channel monitor indication
    output logic [13:0] violation_status,
    // Analog trims
    output lcvc_pkg::lcvc_trim_t trim_out,
    // Reference clocks
    output logic t1_refclk_pin,
    output logic e1_refclk_pin,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Channel code is valid for 0001..1110 only
    // Code 1111 has no channel and is treated like 0000
    function automatic logic chan_valid(input logic [3:0] code);
        chan_valid = (code != 4'h0) && (code != 4'hf);
    endfunction

    // Channel index from a valid code
    function automatic logic [3:0] chan_index(input logic [3:0] code);
        chan_index = code - 4'h1;
    endfunction

    // Phase increment for base frequency times 2^code
    // Base and mclk rate are constants, so synthesis folds the
    // division into a four-entry table selected by the code
    // Accumulator is 32 bits, so the rate error is below 1 ppm
    function automatic logic [31:0] phase_inc(input int base_khz,
                                              input logic [1:0] code);
        logic [63:0] num;
        num = (64'(base_khz) << code) << 32;
        phase_inc = 32'(num / 64'(`LCVC_MCLK_KHZ));
    endfunction

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    lcvc_pkg::lcvc_state_t s_reg; // Current state
    lcvc_pkg::lcvc_state_t s_next; // Next state

    // Decoded command bits, for readability
    logic [3:0] ch_code;
    logic ch_ok;
    logic [3:0] ch_idx;
    logic rst_any;
    logic rst_fire;
    logic [1:0] eq_code;

    // Index is meaningless for codes 0000 and 1111, so each
    // use of it is qualified by ch_ok
    // Commands and the byte read path share this decode
    // Decode is combinational from flops, one level deep
    assign ch_code = s_reg.ctl_reg[`LCVC_CH_HI:`LCVC_CH_LO];
    assign ch_ok = chan_valid(ch_code);
    assign ch_idx = chan_index(ch_code);
    assign rst_any = s_reg.cmd_reg[`LCVC_RST_ALL_BIT] |
                     s_reg.cmd_reg[`LCVC_RST_ONE_BIT];
    assign rst_fire = rst_any &&
        (s_reg.rst_cyc_reg >= 6'(`LCVC_RST_HOLD_CYC));
    assign eq_code = s_reg.trim_reg[`LCVC_EQ_HI:`LCVC_EQ_LO];

    // ------------------------------------------------------------
    // Next state logic
    // ------------------------------------------------------------
    always_comb begin
        logic hit;
        logic [15:0] live;
        logic [13:0] ovf_now;
        logic [13:0] clr_lo;
        logic [13:0] clr_hi;
        logic [15:0] held;
        hit = 1'b0;
        live = 16'h0000;
        ovf_now = 14'h0000;
        clr_lo = 14'h0000;
        clr_hi = 14'h0000;
        held = 16'h0000;
        s_next = s_reg;

        // Register writes; reserved bits of e3 to e6 stored as written, mask high bits 7:6 dropped
        // Writes to the byte register are dropped, it is read only
        // Status bytes are write-one-to-clear, masks plain storage
        // Writes land at the strobe edge, usable one cycle later
        if (wr) begin
            unique case (addr)
                `LCVC_OFS_TRIM: s_next.trim_reg = wdata;
                `LCVC_OFS_CLKSEL: s_next.clksel_reg = wdata;
                `LCVC_OFS_CTL: s_next.ctl_reg = wdata;
                `LCVC_OFS_CMD: s_next.cmd_reg = wdata;
                `LCVC_OFS_STS_LO: clr_lo = {6'h00, wdata};
                `LCVC_OFS_STS_HI: clr_hi = {wdata[5:0], 8'h00};
                `LCVC_OFS_MSK_LO: s_next.msk_reg[7:0] = wdata;
                `LCVC_OFS_MSK_HI: s_next.msk_reg[13:8] = wdata[5:0];
                // Byte register and unmapped writes ignored
                default: ;
            endcase
        end

        // Reset hold timer counts while a reset bit stays set
        // Timer stops at the hold count, so it never wraps and
        // a long held reset keeps firing every cycle
        // Dropping both reset bits re-arms the timer from zero
        if (!rst_any) begin
            s_next.rst_cyc_reg = 6'h00;
        end else if (!rst_fire) begin
            s_next.rst_cyc_reg = s_reg.rst_cyc_reg + 6'h01;
        end

        // Per-channel counters and holding registers
        // Reset beats counting, so a held reset keeps zero
        // Update copies the pre-edge count and lags by one cycle
        // A held update bit keeps the snapshot tracking the count
        for (int i = 0; i < `LCVC_NUM_CH; i++) begin
            hit = ch_ok && (ch_idx == 4'(i));
            live = s_reg.cnt_reg[i];
            if (rst_fire && (s_reg.cmd_reg[`LCVC_RST_ALL_BIT] ||
                (s_reg.cmd_reg[`LCVC_RST_ONE_BIT] && hit))) begin
                s_next.cnt_reg[i] = 16'h0000;
            end else if (line_code_violation[i] &&
                         live != `LCVC_CNT_FULL) begin
                s_next.cnt_reg[i] = live + 16'h0001;
            end
            if (s_reg.cmd_reg[`LCVC_ALLUPD_BIT] ||
                (s_reg.cmd_reg[`LCVC_CHUPD_BIT] && hit)) begin
                s_next.hold_reg[i] = live;
            end
            ovf_now[i] = (live == `LCVC_CNT_FULL);
        end
        s_next.ovf_reg = ovf_now;

        // Sticky status: new overflow wins over a clear
        // Set only on the rising edge of overflow, so a counter
        // that stays saturated does not re-raise a cleared bit
        // Interrupt uses next values to save a cycle of delay
        s_next.sts_reg = (s_reg.sts_reg & ~(clr_lo | clr_hi)) |
                         (ovf_now & ~s_reg.ovf_reg);
        s_next.irq_reg = |(s_next.sts_reg & s_next.msk_reg);

        if (s_reg.ctl_reg[`LCVC_MON_BIT]) begin
            s_next.vstat_reg = ovf_now;
        end else begin
            s_next.vstat_reg = line_code_violation;
        end

        // Slicer code passes straight through
        s_next.trim_out_reg.slicer_threshold =
            s_reg.trim_reg[`LCVC_SL_HI:`LCVC_SL_LO];
        unique case (eq_code)
            2'b01: s_next.trim_out_reg.eq_gain_reduce_db = 2'h1;
            2'b10: s_next.trim_out_reg.eq_gain_reduce_db = 2'h3;
            default: s_next.trim_out_reg.eq_gain_reduce_db = 2'h0;
        endcase

        // Reference clocks from phase accumulators; the edge jitter
        // is one mclk period, the average rate is exact to the count
        // A new rate applies from the next edge with no glitch
        // beyond the jitter already present
        // Pins are one more flop behind the accumulator MSB
        // T1 rate from select
        s_next.t1_acc_reg = s_reg.t1_acc_reg + phase_inc(
            `LCVC_T1_BASE_KHZ, s_reg.clksel_reg[`LCVC_T1_HI:`LCVC_T1_LO]);
        s_next.e1_acc_reg = s_reg.e1_acc_reg + phase_inc(
            `LCVC_E1_BASE_KHZ, s_reg.clksel_reg[`LCVC_E1_HI:`LCVC_E1_LO]);
        s_next.t1_pin_reg = s_reg.t1_acc_reg[31];
        s_next.e1_pin_reg = s_reg.e1_acc_reg[31];

        // Counter byte chosen for readback
        if (ch_ok) begin
            held = s_reg.hold_reg[ch_idx];
        end

        // Read data valid the cycle after the strobe
        // Reads have no side effects, so a repeated read is safe
        // Zero when idle keeps a shared read bus quiet
        // Status reads do not clear; software writes ones instead
        s_next.rdata_reg = 8'h00;
        if (rd) begin
            unique case (addr)
                `LCVC_OFS_TRIM: s_next.rdata_reg = s_reg.trim_reg;
                `LCVC_OFS_CLKSEL: s_next.rdata_reg = s_reg.clksel_reg;
                `LCVC_OFS_CTL: s_next.rdata_reg = s_reg.ctl_reg;
                `LCVC_OFS_CMD: s_next.rdata_reg = s_reg.cmd_reg;
                `LCVC_OFS_BYTE: begin
                    if (s_reg.ctl_reg[`LCVC_RDEN_BIT] && ch_ok) begin
                        s_next.rdata_reg =
                            s_reg.cmd_reg[`LCVC_BYTE_HI_BIT] ?
                            held[15:8] : held[7:0];
                    end
                end
                `LCVC_OFS_STS_LO: s_next.rdata_reg = s_reg.sts_reg[7:0];
                `LCVC_OFS_STS_HI:
                    s_next.rdata_reg = {2'h0, s_reg.sts_reg[13:8]};
                `LCVC_OFS_MSK_LO: s_next.rdata_reg = s_reg.msk_reg[7:0];
                `LCVC_OFS_MSK_HI:
                    s_next.rdata_reg = {2'h0, s_reg.msk_reg[13:8]};
                // Unmapped reads return zero
                default: s_next.rdata_reg = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State flip-flops, frozen while clk_en is low
    // ------------------------------------------------------------
    // Reset loads constants only; every field resets to zero
    // Enable gates the whole struct, including read data and
    // the accumulators, so a frozen clock pin just stops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    // No logic after the flops, so output timing is clean
    // and every output holds its reset value during reset
    // Plain renames of struct fields, one per output
    assign rdata = s_reg.rdata_reg;
    assign violation_status = s_reg.vstat_reg;
    assign trim_out = s_reg.trim_out_reg;
    assign t1_refclk_pin = s_reg.t1_pin_reg;
    assign e1_refclk_pin = s_reg.e1_pin_reg;
    assign irq = s_reg.irq_reg;

endmodule

/* tb/lcvc_top_monitor.sv */
// Port checker for the global configuration block
`timescale 1ns/1ns
module lcvc_top_monitor (
    // Clock, reset, enable
    input logic mclk,
    input logic rst_n,
    input logic clk_en,
    // Register port
    input logic [7:0] addr,
    input logic [7:0] wdata,
    input logic wr,
    input logic rd,
    input logic [7:0] rdata,
    // Line side and outputs
    input logic [13:0] line_code_violation,
    input logic [13:0] violation_status,
    input lcvc_pkg::lcvc_trim_t trim_out,
    input logic t1_refclk_pin,
    input logic e1_refclk_pin,
    input logic irq
);
    // Shadows: e3 at 3, e4 at 0, e5 at 1 (by low address bits)
    logic [7:0] shq [0:3];
    logic [13:0] mq; // Mask shadow
    logic [7:0] ctl; // Counter control shadow
    logic [3:0] tx; // Expected trim outputs
    logic [7:0] cur; // Shadow at current address
    logic gate_off; // Readback must give zero
    logic rde8, rdrw, rdok;
    assign ctl = shq[1];
    assign cur = shq[addr[1:0]];
    assign tx = {shq[3][3:2], shq[3][1] & ~shq[3][0], shq[3][1] ^ shq[3][0]};
    assign gate_off = !ctl[6] || ctl[3:0] == 4'h0 || ctl[3:0] == 4'hf;
    assign rdok = rd && clk_en;
    assign rde8 = rdok && addr == 8'he8;
    assign rdrw = rdok && addr inside {8'he3, 8'he4, 8'he5};
    // Shadows follow accepted writes only, so a frozen cycle is no write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shq <= '{default: 8'h00};
            mq <= 14'h0;
        end else if (clk_en && wr) begin
            if (addr inside {8'he3, 8'he4, 8'he5})
                shq[addr[1:0]] <= wdata;
            if (addr == 8'hf2)
                mq[7:0] <= wdata;
            if (addr == 8'hf3)
                mq[13:8] <= wdata[5:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_trim;
        $past(clk_en) |-> trim_out == $past(tx);
    endproperty
    a_trim: assert property (p_trim) else $error("trim decode wrong");
    property p_t1;
        $changed(t1_refclk_pin) |-> ##[1:24] $changed(t1_refclk_pin);
    endproperty
    a_t1: assert property (p_t1) else $error("t1 clock stalled");
    property p_e1;
        $changed(e1_refclk_pin) |-> ##[1:18] $changed(e1_refclk_pin);
    endproperty
    a_e1: assert property (p_e1) else $error("e1 clock stalled");
    property p_mon;
        $past(clk_en) && !$past(ctl[7])
            |-> violation_status == $past(line_code_violation);
    endproperty
    a_mon: assert property (p_mon) else $error("live monitor wrong");
    property p_gate;
        $past(rde8) && $past(gate_off) |-> rdata == 8'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("gated read");
    property p_rw;
        $past(rdrw) |-> rdata == $past(cur);
    endproperty
    a_rw: assert property (p_rw) else $error("readback wrong");
    property p_idle;
        $past(clk_en) && !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_irq;
        $past(clk_en) && mq == 14'h0 |-> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("masked irq seen");
    // Main scenarios reached
    c_byte: cover property ($past(rde8) && rdata != 8'h00);
    c_irq: cover property ($rose(irq));
    c_ovf: cover property (ctl[7] && violation_status != 14'h0);
endmodule

bind lcvc_top lcvc_top_monitor u_lcvc_top_monitor (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .line_code_violation(line_code_violation),
    .violation_status(violation_status), .trim_out(trim_out),
    .t1_refclk_pin(t1_refclk_pin), .e1_refclk_pin(e1_refclk_pin),
    .irq(irq));

/* tb/lcvc_top_test.sv */
// Self-checking bench for the global configuration block
`timescale 1ns/1ns
module lcvc_top_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [13:0] viol = 14'h0; // Violation pulses
    logic [7:0] rdata;
    logic [13:0] vst; // Monitor indication
    lcvc_pkg::lcvc_trim_t trim;
    logic t1p, e1p, irq;
    logic [1:0] eqx [0:3] = '{2'h0, 2'h1, 2'h3, 2'h0}; // Gain cuts in dB
    int n_errors = 0;
    int total_checks = 0;

    lcvc_top u_lcvc_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .line_code_violation(viol), .violation_status(vst),
        .trim_out(trim), .t1_refclk_pin(t1p), .e1_refclk_pin(e1p),
        .irq(irq));

    // 50 MHz clock
    initial begin
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Edge counts in tenths; start phase costs up to two edges
    task automatic chk_freq(input int got, input int exp);
        total_checks++;
        if (got > exp + 20 || got < exp - 20) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic t_regs;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr_reg(8'he3, {4'ha, c, c});
            cyc(2);
            chk(trim, {c, eqx[i]});
            rd_reg(8'he3, {4'ha, c, c});
        end
        wr_reg(8'he4, 8'h0f);
        rd_reg(8'he4, 8'h0f);
        wr_reg(8'he5, 8'h30);
        rd_reg(8'he5, 8'h30);
        wr_reg(8'he7, 8'h55);
        rd_reg(8'he7, 8'h00);
    endtask
    task automatic t_clk;
        int nt, ne;
        logic pt, pe;
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'he4, {c[1:0], c[1:0], 4'h0});
            nt = 0;
            ne = 0;
            pt = t1p;
            pe = e1p;
            repeat (5000) begin
                @(negedge mclk);
                if (t1p && !pt)
                    nt++;
                if (e1p && !pe)
                    ne++;
                pt = t1p;
                pe = e1p;
            end
            chk_freq(nt * 10, 1544 << c);
            chk_freq(ne * 10, 2048 << c);
        end
    endtask
    // Counts on channels 0 to 2, with a frozen gap that must not count
    task automatic t_count;
        wr_reg(8'he5, 8'h43);
        viol <= 14'h0007;
        cyc(3);
        viol <= 14'h0004;
        clk_en <= 1'b0;
        cyc(3);
        clk_en <= 1'b1;
        cyc(2);
        viol <= 14'h0;
        wr_reg(8'he6, 8'h02);
        wr_reg(8'he6, 8'h00);
        rd_reg(8'he8, 8'h05);
        wr_reg(8'he5, 8'h42);
        rd_reg(8'he8, 8'h00);
        wr_reg(8'he6, 8'h08);
        wr_reg(8'he6, 8'h00);
        rd_reg(8'he8, 8'h03);
        wr_reg(8'he6, 8'h04);
        rd_reg(8'he8, 8'h00);
        // Low byte again, so an ungated read would show a count
        wr_reg(8'he6, 8'h00);
        wr_reg(8'he5, 8'h02);
        rd_reg(8'he8, 8'h00);
        wr_reg(8'he5, 8'h40);
        rd_reg(8'he8, 8'h00);
        wr_reg(8'he5, 8'h43);
        wr_reg(8'he6, 8'h01);
        cyc(50);
        wr_reg(8'he6, 8'h02);
        wr_reg(8'he6, 8'h00);
        rd_reg(8'he8, 8'h00);
        wr_reg(8'he5, 8'h42);
        rd_reg(8'he8, 8'h03);
    endtask
    // Saturate every counter, then overflow monitor, interrupt, reset all
    task automatic t_sat;
        viol <= 14'h3fff;
        cyc(65540);
        viol <= 14'h0;
        wr_reg(8'he5, 8'hce);
        wr_reg(8'he6, 8'h08);
        wr_reg(8'he6, 8'h04);
        rd_reg(8'he8, 8'hff);
        wr_reg(8'he6, 8'h00);
        rd_reg(8'he8, 8'hff);
        chk(vst, 14'h3fff);
        rd_reg(8'hf0, 8'hff);
        rd_reg(8'hf1, 8'h3f);
        chk(irq, 1'b0);
        wr_reg(8'hf2, 8'hff);
        cyc(2);
        chk(irq, 1'b1);
        wr_reg(8'hf0, 8'hff);
        wr_reg(8'hf1, 8'h3f);
        cyc(2);
        chk(irq, 1'b0);
        wr_reg(8'he6, 8'h10);
        cyc(50);
        wr_reg(8'he6, 8'h00);
        cyc(2);
        chk(vst, 14'h0);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Reset values of the three global bytes
    task automatic t_reset;
        rd_reg(8'he3, 8'h00);
        rd_reg(8'he4, 8'h00);
        rd_reg(8'he5, 8'h00);
    endtask
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_clk;
        t_count;
        t_sat;
        report_and_stop;
    end
endmodule
